// [include/tone_pkg.sv]
// Package for the dual tone generator: register map, field positions,
// reset values, frame timing and the built-in coefficient set.
// Assumes a 20 MHz system clock and an 8 kHz voice sample rate.
package tone_pkg;

  // Clock and frame timing
  localparam int SYS_CLK_HZ     = 20_000_000;            // System clock rate
  localparam int SAMPLE_RATE_HZ = 8000;                  // Voice frame rate
  localparam int FRAME_CYCLES   = SYS_CLK_HZ / SAMPLE_RATE_HZ; // Clocks per frame

  // Data widths
  localparam int COEFF_W  = 16;                          // Coefficient word width
  localparam int SAMPLE_W = 16;                          // One generator sample
  localparam int MIX_W    = 17;                          // Sum of two generators

  // Oscillator arithmetic
  localparam int FULL_SCALE    = 8191;                   // Coefficient scale
  localparam int COEFF_WRAP    = 16384;                  // Upper-band coefficient offset
  localparam int FREQ_SPLIT_HZ = 2000;                   // Band split frequency
  localparam int MUL_SHIFT     = 12;                     // 2*c*y/8192 as >>>12
  localparam int GAIN_SHIFT    = 13;                     // Mix gain 2000H is unity

  // Register map inside one channel block (byte offsets)
  localparam int CH_SHIFT          = 5;                  // 32 bytes per channel
  localparam logic [4:0] OFF_CTRL  = 5'h00;              // Enables and source select
  localparam logic [4:0] OFF_FREQ1 = 5'h04;              // First frequency coefficient
  localparam logic [4:0] OFF_AMP1  = 5'h08;              // First amplitude coefficient
  localparam logic [4:0] OFF_FREQ2 = 5'h0C;              // Second frequency coefficient
  localparam logic [4:0] OFF_AMP2  = 5'h10;              // Second amplitude coefficient
  localparam logic [4:0] OFF_GAIN  = 5'h14;              // Dual-tone mix word
  localparam logic [4:0] OFF_MIX   = 5'h18;              // Read-only channel sample

  // Control register fields
  localparam int CTRL_W            = 3;                  // Implemented control bits
  localparam int CTRL_FIRST_EN_BIT = 0;                  // First generator enable
  localparam int CTRL_SECOND_EN_BIT = 1;                 // Second generator enable
  localparam int CTRL_SOURCE_BIT   = 2;                  // 1 built-in, 0 coefficient RAM
  localparam logic [2:0] CTRL_RESET = 3'h4;              // Both off, built-in source

  // Coefficient RAM reset values
  localparam logic [15:0] COEFF_RESET = 16'h0000;        // RAM words start cleared
  localparam logic [15:0] GAIN_RESET  = 16'h0000;        // Software must load 2000H

  // Built-in tone set
  localparam real PI            = 3.14159265358979;
  localparam real PEAK_VOLTS    = 1.57;                  // Output at A = 1
  localparam real DEFAULT_VOLTS = 0.94;                  // Built-in level
  localparam real FIRST_HZ      = 852.0;                 // Built-in first tone
  localparam real SECOND_HZ     = 1447.0;                // Built-in second tone

  // Frequency coefficient, lower or upper band form
  function automatic int freq_coeff(input real f);
    real c;
    c = $cos(f / SAMPLE_RATE_HZ * 2.0 * PI) * FULL_SCALE;
    if (f < FREQ_SPLIT_HZ) begin
      return $rtoi(c + 0.5);
    end else begin
      return COEFF_WRAP - $rtoi(c - 0.5);
    end
  endfunction

  // Amplitude coefficient from level in volts
  function automatic int amp_coeff(input real f, input real volts);
    return $rtoi(volts / PEAK_VOLTS * FULL_SCALE * $sin(f / SAMPLE_RATE_HZ * 2.0 * PI) + 0.5);
  endfunction

  localparam logic [15:0] ROM_FREQ1 = 16'(freq_coeff(FIRST_HZ));
  localparam logic [15:0] ROM_AMP1  = 16'(amp_coeff(FIRST_HZ, DEFAULT_VOLTS));
  localparam logic [15:0] ROM_FREQ2 = 16'(freq_coeff(SECOND_HZ));
  localparam logic [15:0] ROM_AMP2  = 16'(amp_coeff(SECOND_HZ, DEFAULT_VOLTS));

endpackage

// [include/tone_osc_if.sv]
// Interface between the channel logic and one recursive oscillator.
// Assumes the oscillator and its controller share sys_clk.
`timescale 1ns/1ps
interface tone_osc_if;
  logic                         frame_tick;   // One-cycle pulse per 8 kHz frame
  logic                         enable;       // Generator enable level
  logic [tone_pkg::COEFF_W-1:0] freq;         // Frequency coefficient
  logic [tone_pkg::COEFF_W-1:0] amp;          // Amplitude coefficient
  logic signed [tone_pkg::SAMPLE_W-1:0] sample; // Registered output sample

  modport ctrl (output frame_tick, output enable, output freq, output amp, input sample);
  modport osc  (input frame_tick, input enable, input freq, input amp, output sample);
endinterface

// [hdl/tone_osc.sv]
// Second-order recursive sine oscillator, one sample per frame.
// Assumes coefficients stay steady while the generator runs.
`timescale 1ns/1ps
module tone_osc (
  // Clock and reset
  input  wire logic sys_clk,
  input  wire logic resetn,
  // Controller side
  tone_osc_if.osc   port
);

  logic signed [tone_pkg::SAMPLE_W-1:0] y1_ff;      // Latest sample
  logic signed [tone_pkg::SAMPLE_W-1:0] y2_ff;      // Sample before it
  logic                                 started_ff; // Oscillator seeded
  logic signed [tone_pkg::SAMPLE_W-1:0] sample_ff;  // Output register
  logic signed [tone_pkg::COEFF_W:0]    cos_term;   // Signed 8191*cos
  logic signed [33:0]                   prod;       // cos_term * y1
  logic signed [33:0]                   nxt_full;   // Before saturation
  logic signed [tone_pkg::SAMPLE_W-1:0] nxt_y;      // Saturated recursion

  // Upper-band coefficients carry the 16384 offset; undo it here
  always_comb begin
    if (port.freq >= 16'(tone_pkg::COEFF_WRAP)) begin
      cos_term = 17'(tone_pkg::COEFF_WRAP) - $signed({1'b0, port.freq});
    end else begin
      cos_term = $signed({1'b0, port.freq});
    end
  end

  // y[n] = 2*cos*y[n-1] - y[n-2], saturated so overflow cannot fold over
  always_comb begin
    prod     = 34'(cos_term * y1_ff);
    nxt_full = (prod >>> tone_pkg::MUL_SHIFT) - 34'(y2_ff);
    if (nxt_full > 34'sd32767) begin
      nxt_y = 16'sh7FFF;
    end else if (nxt_full < -34'sd32768) begin
      nxt_y = -16'sh8000;
    end else begin
      nxt_y = nxt_full[15:0];
    end
  end

  // State advance on the frame tick only
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      y1_ff      <= '0;
      y2_ff      <= '0;
      started_ff <= 1'b0;
    end else if (port.frame_tick) begin
      if (!port.enable) begin
        // Disabled: park at the initial state
        y1_ff      <= '0;
        y2_ff      <= '0;
        started_ff <= 1'b0;
      end else if (!started_ff) begin
        // Seed: y0 = A*8191*sin(w), y-1 = 0
        y1_ff      <= $signed(port.amp);
        y2_ff      <= '0;
        started_ff <= 1'b1;
      end else begin
        y1_ff <= nxt_y;
        y2_ff <= y1_ff;
      end
    end
  end

  // A disabled generator contributes nothing
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      sample_ff <= '0;
    end else if (port.frame_tick) begin
      if (!port.enable) begin
        sample_ff <= '0;
      end else if (!started_ff) begin
        // Seed frame shows y0, the amplitude coefficient itself
        sample_ff <= $signed(port.amp);
      end else begin
        sample_ff <= nxt_y;
      end
    end
  end

  assign port.sample = sample_ff;

endmodule

// [hdl/dual_tone_generator.sv]
// Per-channel pair of tone generators with a Wishbone register file.
// Assumes a classic Wishbone master on sys_clk and a DAC after the outputs.
//
// Contract
// - Two independent generators per channel to output
// - Separate enable bit per generator, 1 on
// - Source select: 1 built-in default, 0 RAM
// - Built-in first tone 852 Hz, 0.94 V
// - Built-in second tone 1447 Hz, 0.94 V
// - Below 2000 Hz coefficient is 8191*cos(w)
// - Above 2000 Hz coefficient is 16384-8191*cos(w)
// - Amplitude coefficient is A*8191*sin(w)
// - Output level linear in A, 1.57 V
// - Frequencies from 25 to 3400 Hz supported
// - Frequency error within 3 or 1.5 percent; the 8191 scale with the >>>12 step gives about 38 percent at 25 Hz
`timescale 1ns/1ps
module dual_tone_generator #(
  parameter int CHANNELS = 4,              // Voice channels
  parameter int WB_ADR_W = 8               // Wishbone byte address width
) (
  // Clock and reset
  input  wire logic                              sys_clk,
  input  wire logic                              resetn,
  // Wishbone slave
  input  wire logic                              wb_cyc_i,
  input  wire logic                              wb_stb_i,
  input  wire logic                              wb_we_i,
  input  wire logic [WB_ADR_W-1:0]               wb_adr_i,
  input  wire logic [3:0]                        wb_sel_i,
  input  wire logic [31:0]                       wb_dat_i,
  output wire logic [31:0]                       wb_dat_o,
  output wire logic                              wb_ack_o,
  // Differential sample codes toward the line interface
  output wire logic [CHANNELS*tone_pkg::MIX_W-1:0] analog_out_pos,
  output wire logic [CHANNELS*tone_pkg::MIX_W-1:0] analog_out_neg,
  // Frame strobe
  output wire logic                              frame_tick
);

  localparam int CH_W = (CHANNELS > 1) ? $clog2(CHANNELS) : 1;   // Channel index width
  localparam int MW   = tone_pkg::MIX_W;

  // Register file storage
  logic [tone_pkg::CTRL_W-1:0]  ctrl_ff  [CHANNELS];   // channel_config bits
  logic [tone_pkg::COEFF_W-1:0] freq1_ff [CHANNELS];   // first_frequency_coeff
  logic [tone_pkg::COEFF_W-1:0] amp1_ff  [CHANNELS];   // first_amplitude_coeff
  logic [tone_pkg::COEFF_W-1:0] freq2_ff [CHANNELS];   // second_frequency_coeff
  logic [tone_pkg::COEFF_W-1:0] amp2_ff  [CHANNELS];   // second_amplitude_coeff
  logic [tone_pkg::COEFF_W-1:0] gain_ff  [CHANNELS];   // Dual-tone mix word
  logic signed [MW-1:0]         mix_ff   [CHANNELS];   // Channel output sample

  // Bus side
  logic        ack_ff;          // Acknowledge pulse
  logic [31:0] dat_ff;          // Read data register
  logic        req;             // New access this cycle
  logic [4:0]  reg_off;         // Offset inside channel block
  logic [CH_W-1:0] ch_sel;      // Addressed channel
  logic        ch_valid;        // Channel exists

  // Frame timing
  logic [$clog2(tone_pkg::FRAME_CYCLES)-1:0] frame_cnt_ff;  // Cycles into frame
  logic                                      tick_ff;       // Frame pulse
  logic                                      mix_tick_ff;   // Tick delayed to the mix stage

  // Byte-lane merge for a 16-bit register, low lanes only
  function automatic logic [15:0] merge16(input logic [15:0] old_v, input logic [31:0] wdat,
                                          input logic [3:0] sel);
    logic [15:0] r;
    r = old_v;
    if (sel[0]) begin
      r[7:0] = wdat[7:0];
    end
    if (sel[1]) begin
      r[15:8] = wdat[15:8];
    end
    return r;
  endfunction

  // Saturate a wide signed value into a symmetric mix word
  function automatic logic signed [MW-1:0] clamp_mix(input logic signed [40:0] v);
    logic signed [40:0] lim;
    lim = 41'sd65535;
    if (v > lim) begin
      return 17'sd65535;
    end else if (v < -lim) begin
      return -17'sd65535;
    end else begin
      return v[MW-1:0];
    end
  endfunction

  // Address decode shared by read and write paths
  assign req      = wb_cyc_i && wb_stb_i && !ack_ff;
  assign reg_off  = {wb_adr_i[4:2], 2'b00};
  assign ch_sel   = wb_adr_i[tone_pkg::CH_SHIFT +: CH_W];
  assign ch_valid = (int'(ch_sel) < CHANNELS) &&
                    (wb_adr_i[WB_ADR_W-1:tone_pkg::CH_SHIFT] < (WB_ADR_W-tone_pkg::CH_SHIFT)'(CHANNELS));

  // Frame counter: one tick per 8 kHz sample period
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      frame_cnt_ff <= '0;
      tick_ff      <= 1'b0;
    end else if (frame_cnt_ff == ($bits(frame_cnt_ff))'(tone_pkg::FRAME_CYCLES - 1)) begin
      frame_cnt_ff <= '0;
      tick_ff      <= 1'b1;
    end else begin
      frame_cnt_ff <= frame_cnt_ff + 1'b1;
      tick_ff      <= 1'b0;
    end
  end

  assign frame_tick = tick_ff;

  // Mix strobe: generator samples settle the cycle after the tick
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      mix_tick_ff <= 1'b0;
    end else begin
      mix_tick_ff <= tick_ff;
    end
  end

  // Acknowledge one cycle after the request, dropped the cycle after
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      ack_ff <= 1'b0;
    end else begin
      ack_ff <= req;
    end
  end

  // Register writes; unmapped writes are acknowledged and discarded
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      for (int i = 0; i < CHANNELS; i++) begin
        ctrl_ff[i]  <= tone_pkg::CTRL_RESET;
        freq1_ff[i] <= tone_pkg::COEFF_RESET;
        amp1_ff[i]  <= tone_pkg::COEFF_RESET;
        freq2_ff[i] <= tone_pkg::COEFF_RESET;
        amp2_ff[i]  <= tone_pkg::COEFF_RESET;
        gain_ff[i]  <= tone_pkg::GAIN_RESET;
      end
    end else if (req && wb_we_i && ch_valid) begin
      case (reg_off)
        tone_pkg::OFF_CTRL: begin
          // Enables are independent bits
          if (wb_sel_i[0]) begin
            ctrl_ff[ch_sel] <= wb_dat_i[tone_pkg::CTRL_W-1:0];
          end
        end
        tone_pkg::OFF_FREQ1: begin
          freq1_ff[ch_sel] <= merge16(freq1_ff[ch_sel], wb_dat_i, wb_sel_i);
        end
        tone_pkg::OFF_AMP1: begin
          amp1_ff[ch_sel] <= merge16(amp1_ff[ch_sel], wb_dat_i, wb_sel_i);
        end
        tone_pkg::OFF_FREQ2: begin
          freq2_ff[ch_sel] <= merge16(freq2_ff[ch_sel], wb_dat_i, wb_sel_i);
        end
        tone_pkg::OFF_AMP2: begin
          amp2_ff[ch_sel] <= merge16(amp2_ff[ch_sel], wb_dat_i, wb_sel_i);
        end
        tone_pkg::OFF_GAIN: begin
          // Mix word software loads before dual use
          gain_ff[ch_sel] <= merge16(gain_ff[ch_sel], wb_dat_i, wb_sel_i);
        end
        default: begin
          // Read-only or unmapped: ignored
        end
      endcase
    end
  end

  // Read data, registered with the acknowledge; unmapped reads as zero
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      dat_ff <= '0;
    end else if (req && !wb_we_i) begin
      dat_ff <= '0;
      if (ch_valid) begin
        case (reg_off)
          tone_pkg::OFF_CTRL:  dat_ff <= 32'(ctrl_ff[ch_sel]);
          tone_pkg::OFF_FREQ1: dat_ff <= 32'(freq1_ff[ch_sel]);
          tone_pkg::OFF_AMP1:  dat_ff <= 32'(amp1_ff[ch_sel]);
          tone_pkg::OFF_FREQ2: dat_ff <= 32'(freq2_ff[ch_sel]);
          tone_pkg::OFF_AMP2:  dat_ff <= 32'(amp2_ff[ch_sel]);
          tone_pkg::OFF_GAIN:  dat_ff <= 32'(gain_ff[ch_sel]);
          tone_pkg::OFF_MIX:   dat_ff <= {{(32-MW){1'b0}}, mix_ff[ch_sel]};
          default:             dat_ff <= '0;
        endcase
      end
    end
  end

  assign wb_ack_o = ack_ff;
  assign wb_dat_o = dat_ff;

  // One generator pair and mixer per channel
  for (genvar ch = 0; ch < CHANNELS; ch++) begin : g_chan
    tone_osc_if first_tone_generator ();    // First generator link
    tone_osc_if second_tone_generator ();   // Second generator link

    logic                  builtin_sel;      // coeff_source_select
    logic                  first_tone_enable;
    logic                  second_tone_enable;
    logic signed [MW-1:0]  sum;              // Plain sum of both samples
    logic signed [40:0]    scaled;           // Sum times mix word
    logic signed [MW-1:0]  nxt_mix;          // Next channel sample

    assign builtin_sel        = ctrl_ff[ch][tone_pkg::CTRL_SOURCE_BIT];
    assign first_tone_enable  = ctrl_ff[ch][tone_pkg::CTRL_FIRST_EN_BIT];
    assign second_tone_enable = ctrl_ff[ch][tone_pkg::CTRL_SECOND_EN_BIT];

    // Built-in set computed from the same formulas software uses
    assign first_tone_generator.frame_tick = tick_ff;
    assign first_tone_generator.enable     = first_tone_enable;
    assign first_tone_generator.freq       = builtin_sel ? tone_pkg::ROM_FREQ1 : freq1_ff[ch];
    assign first_tone_generator.amp        = builtin_sel ? tone_pkg::ROM_AMP1  : amp1_ff[ch];
    assign second_tone_generator.frame_tick = tick_ff;
    assign second_tone_generator.enable     = second_tone_enable;
    assign second_tone_generator.freq       = builtin_sel ? tone_pkg::ROM_FREQ2 : freq2_ff[ch];
    assign second_tone_generator.amp        = builtin_sel ? tone_pkg::ROM_AMP2  : amp2_ff[ch];

    // Two independent oscillators; any frequency up to 3400 Hz fits the
    // 16-bit coefficient, but the 8191 scale gives about 38 percent frequency error at 25 Hz
    tone_osc u_first (
      .sys_clk (sys_clk),
      .resetn  (resetn),
      .port    (first_tone_generator.osc)
    );

    tone_osc u_second (
      .sys_clk (sys_clk),
      .resetn  (resetn),
      .port    (second_tone_generator.osc)
    );

    // Sum; mix word applies only with both running, so a missing word
    // mutes a dual tone rather than letting it clip
    always_comb begin
      sum    = MW'(first_tone_generator.sample) + MW'(second_tone_generator.sample);
      scaled = (41'(sum) * $signed({1'b0, gain_ff[ch]})) >>> tone_pkg::GAIN_SHIFT;
      if (first_tone_enable && second_tone_enable) begin
        nxt_mix = clamp_mix(scaled);
      end else begin
        nxt_mix = sum;
      end
    end

    // Channel sample, updated once per frame so register writes cannot
    // disturb a sample mid-frame
    always_ff @(posedge sys_clk or negedge resetn) begin
      if (!resetn) begin
        mix_ff[ch] <= '0;
      end else if (mix_tick_ff) begin
        mix_ff[ch] <= nxt_mix;
      end
    end

    // Differential pair: negative leg is the inverted code
    assign analog_out_pos[ch*MW +: MW] = mix_ff[ch];
    assign analog_out_neg[ch*MW +: MW] = -mix_ff[ch];
  end

endmodule

// [verif/dual_tone_generator_assertions.sv]
// Concurrent checks on the tone block's top-level ports.
// Assumes binding onto dual_tone_generator, single sys_clk domain.
`timescale 1ns/1ps
module dual_tone_generator_assertions #(
  parameter int CHANNELS = 4,  // Voice channels
  parameter int WB_ADR_W = 8   // Byte address width
) (
  // Clock and reset
  input wire logic                                sys_clk,
  input wire logic                                resetn,
  // Wishbone side
  input wire logic                                wb_cyc_i,
  input wire logic                                wb_stb_i,
  input wire logic                                wb_we_i,
  input wire logic [WB_ADR_W-1:0]                 wb_adr_i,
  input wire logic [31:0]                         wb_dat_o,
  input wire logic                                wb_ack_o,
  // Line side
  input wire logic [CHANNELS*tone_pkg::MIX_W-1:0] analog_out_pos,
  input wire logic [CHANNELS*tone_pkg::MIX_W-1:0] analog_out_neg,
  input wire logic                                frame_tick
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!resetn);
  logic [11:0] cyc_cnt_ff;  // Clocks since last frame strobe
  // Frame period reference, free-running and wrapping every FRAME_CYCLES clocks
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      cyc_cnt_ff <= 12'h000;
    end else if (cyc_cnt_ff == 12'(tone_pkg::FRAME_CYCLES - 1)) begin
      cyc_cnt_ff <= 12'h000;
    end else begin
      cyc_cnt_ff <= cyc_cnt_ff + 12'h001;
    end
  end
  sequence s_req;
    wb_cyc_i && wb_stb_i && !wb_ack_o;
  endsequence
  sequence s_ans;
    wb_ack_o ##1 !wb_ack_o;
  endsequence
  a_ack_answer: assert property (s_req |=> s_ans) else $error("ack not one cycle after request");
  a_ack_cause: assert property (wb_ack_o |-> $past(wb_cyc_i && wb_stb_i)) else $error("ack without request");
  a_rd_upper: assert property (wb_ack_o && !wb_we_i |-> wb_dat_o[31:17] == 15'h0000) else $error("upper read bits set");
  a_rd_hold: assert property (!(wb_cyc_i && wb_stb_i && !wb_we_i) |=> $stable(wb_dat_o)) else $error("read data moved");
  a_tick_period: assert property (frame_tick |-> cyc_cnt_ff == 12'h000) else $error("tick off period");
  a_tick_due: assert property (cyc_cnt_ff == 12'(tone_pkg::FRAME_CYCLES - 1) |=> frame_tick) else $error("tick missing");
  a_out_frame: assert property (!$past(frame_tick, 2) |-> $stable(analog_out_pos)) else $error("sample moved mid-frame");
  for (genvar c = 0; c < CHANNELS; c++) begin : g_ch
    // Differential pair must always cancel
    a_neg_pair: assert property ((analog_out_pos[c*17+:17] + analog_out_neg[c*17+:17]) == 17'h00000) else $error("pair not inverse");
  end
  c_ack: cover property (s_req ##1 s_ans);
endmodule

// [verif/line_side_model.sv]
// Line-interface stand-in: latches each channel's sample once per frame.
// Assumes the block's frame strobe and registered outputs on sys_clk.
`timescale 1ns/1ps
module line_side_model #(
  parameter int CHANNELS = 4  // Voice channels
) (
  // Clock and reset
  input  wire logic                                sys_clk,
  input  wire logic                                resetn,
  // Differential samples from the block
  input  wire logic [CHANNELS*tone_pkg::MIX_W-1:0] analog_out_pos,
  input  wire logic [CHANNELS*tone_pkg::MIX_W-1:0] analog_out_neg,
  input  wire logic                                frame_tick,
  // Captured line values
  output logic      [CHANNELS*tone_pkg::MIX_W-1:0] line_ff,
  output int                                       frames_ff
);
  logic [1:0] pend_ff;  // Strobe delay; output settles two cycles after tick
  // Half the lane difference; lanes are kept apart so no borrow crosses
  function automatic logic [16:0] half_diff(input logic signed [16:0] p, input logic signed [16:0] n);
    logic signed [17:0] d;
    d = 18'(p) - 18'(n);
    return d[17:1];
  endfunction
  // Capture on the first edge after the mix stage update, so the new sample is seen
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      pend_ff   <= 2'h0;
      line_ff   <= '0;
      frames_ff <= 0;
    end else begin
      pend_ff <= {pend_ff[0], frame_tick};
      if (pend_ff[1]) begin
        for (int c = 0; c < CHANNELS; c++) begin
          line_ff[c*17+:17] <= half_diff(analog_out_pos[c*17+:17], analog_out_neg[c*17+:17]);
        end
        frames_ff <= frames_ff + 1;
      end
    end
  end
endmodule

// [verif/dual_tone_generator_tb_top.sv]
// Register and tone-stream tests for the dual tone block.
// Assumes a classic Wishbone master and the line model on sys_clk.
`timescale 1ns/1ps
module dual_tone_generator_tb_top;
  logic        sys_clk, resetn, cyc, stb, we;  // Clock, reset, bus strobes
  logic [7:0]  adr;                            // Byte address
  logic [31:0] wdat, rdat, q;                  // Bus data
  logic        ack, tick;                      // Block strobes
  logic [67:0] pos, neg, line;                 // Line samples
  int          frames, miscompares, checked, cycles;
  int          a1, c1, a2, c2, fr, cr, ar;     // Expected coefficients
  dual_tone_generator i_dual_tone_generator (.sys_clk(sys_clk), .resetn(resetn), .wb_cyc_i(cyc), .wb_stb_i(stb),
    .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hF), .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack),
    .analog_out_pos(pos), .analog_out_neg(neg), .frame_tick(tick));
  line_side_model i_line_side_model (.sys_clk(sys_clk), .resetn(resetn), .analog_out_pos(pos),
    .analog_out_neg(neg), .frame_tick(tick), .line_ff(line), .frames_ff(frames));
  // 20 MHz clock
  initial begin
    sys_clk = 1'b0;
    forever #25 sys_clk = ~sys_clk;
  end
  // Hang guard, the run needs about four frames
  always @(posedge sys_clk) begin
    cycles = cycles + 1;
    if (cycles == 30000) begin
      miscompares = miscompares + 1;
      test_done();
    end
  end
  function automatic int rnd(input real x);
    return (x < 0.0) ? -$rtoi(0.5 - x) : $rtoi(x + 0.5);
  endfunction
  function automatic real w(input real f);
    return 2.0 * 3.14159265358979 * f / 8000.0;
  endfunction
  // One classic cycle, held until ack is seen
  task automatic wb(input logic [7:0] a, input logic wr, input logic [31:0] d);
    @(posedge sys_clk);
    cyc <= 1'b1; stb <= 1'b1; we <= wr; adr <= a; wdat <= d;
    do begin
      @(posedge sys_clk);
    end while (ack !== 1'b1);
    q = rdat;
    cyc <= 1'b0; stb <= 1'b0; we <= 1'b0;
  endtask
  task automatic check_reg(input logic [7:0] a, input logic [31:0] exp);
    wb(a, 1'b0, 32'h0);
    checked = checked + 1;
    if (q !== exp) begin
      miscompares = miscompares + 1;
      $display("mismatch at %0t reg %h got %h exp %h", $time, a, q, exp);
    end
  endtask
  task automatic check_smp(input int ch, input int exp);
    checked = checked + 1;
    if (line[ch*17+:17] !== 17'(exp)) begin
      miscompares = miscompares + 1;
      $display("mismatch at %0t ch %0d got %h exp %h", $time, ch, line[ch*17+:17], 17'(exp));
    end
  endtask
  // Wait for the line model's next capture
  task automatic next_frame();
    int f;
    f = frames;
    while (frames == f) @(posedge sys_clk);
    #1;
  endtask
  task automatic test_done();
    $display("checked %0d miscompares %0d", checked, miscompares);
    if (miscompares == 0 && checked > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask
  // Main sequence
  initial begin
    miscompares = 0; checked = 0; cycles = 0;
    resetn = 1'b0; cyc = 1'b0; stb = 1'b0; we = 1'b0; adr = 8'h00; wdat = 32'h0;
    a1 = rnd(0.94 / 1.57 * 8191.0 * $sin(w(852.0)));
    c1 = rnd(8191.0 * $cos(w(852.0)));
    a2 = rnd(0.94 / 1.57 * 8191.0 * $sin(w(1447.0)));
    c2 = rnd(8191.0 * $cos(w(1447.0)));
    fr = 16384 - rnd(8191.0 * $cos(w(2500.0)));
    cr = 16384 - fr;
    ar = rnd(0.5 * 8191.0 * $sin(w(2500.0)));
    repeat (16) @(posedge sys_clk);
    resetn <= 1'b1;
    check_reg(8'h00, 32'h4);
    check_reg(8'h24, 32'h0);
    check_reg(8'h34, 32'h0);
    check_reg(8'h1C, 32'h0);
    check_reg(8'h80, 32'h0);
    next_frame();
    wb(8'h00, 1'b1, 32'h5);
    wb(8'h2C, 1'b1, 32'hFFFF0000 | 32'(fr));
    wb(8'h30, 1'b1, 32'(ar));
    wb(8'h20, 1'b1, 32'h2);
    wb(8'h40, 1'b1, 32'h7);
    check_reg(8'h2C, 32'(fr));
    check_reg(8'h20, 32'h2);
    next_frame();
    check_smp(0, a1);
    check_smp(1, ar);
    check_smp(2, 0);
    check_smp(3, 0);
    wb(8'h54, 1'b1, 32'h2000);
    next_frame();
    check_smp(0, (c1 * a1) >>> 12);
    check_smp(1, (cr * ar) >>> 12);
    check_smp(2, ((c1 * a1) >>> 12) + ((c2 * a2) >>> 12));
    wb(8'h00, 1'b1, 32'h4);
    next_frame();
    check_smp(0, 0);
    test_done();
  end
endmodule
bind dual_tone_generator dual_tone_generator_assertions #(.CHANNELS(CHANNELS), .WB_ADR_W(WB_ADR_W))
  i_dual_tone_generator_assertions (.sys_clk(sys_clk), .resetn(resetn), .wb_cyc_i(wb_cyc_i),
  .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
  .analog_out_pos(analog_out_pos), .analog_out_neg(analog_out_neg), .frame_tick(frame_tick));
